// ### inc/fsef_pkg.sv
/*
 * Constants for the flash status and error flag register bank.
 * Assumes a classic Wishbone slave with 32-bit data, one register per word.
 */
// Functional notes
// - Writing command-done one launches; stays low till done
// - Command-done reads 0 busy, 1 complete
// - Sequence violation or illegal command sets access error
// - Access error set blocks launch and clear
// - Access error clears by write one only
// - Protected program or erase sets protection violation
// - Protection violation clears by write one only
// - Protection violation blocks launch and sequence start
// - Busy reads 1 while executing, 0 idle
// - Bit 2 and unassigned bits read zero
// - Completion error bits set on command/reset errors
// - Busy and completion error bits are read only
// - Double fault or read collision sets double fault
// - Double fault clears by write one only
// - Single fault or collision sets single fault flag
// - Single fault clears by write one only
// - Genuine fault reports single or double, never both
// - Read collision sets both fault flags together; with ignore set, the code sets only the double fault flag
// - Error flags readable, writes only clear
// - Reset value may deviate on reset double fault
// - Ignore setting suppresses single fault report and irq
// - Command-done enable requests irq when flag set
// - Double-fault enable requests irq when flag set
// - Single-fault enable requests irq when flag set
package fsef_pkg;
    localparam logic [3:0] IDX_CONFIG     = 4'h4;
    localparam logic [3:0] IDX_ERR_CONFIG = 4'h5;
    localparam logic [3:0] IDX_CMD_STATUS = 4'h6;
    localparam logic [3:0] IDX_ERR_STATUS = 4'h7;
    // Command status fields
    localparam int BIT_DONE    = 7;
    localparam int BIT_ACCESS_ERROR_FLAG  = 5;
    localparam int BIT_PROT    = 4;
    localparam int BIT_BUSY    = 3;
    localparam int BIT_CSTAT_H = 1;
    localparam int BIT_CSTAT_L = 0;
    // Error status fields
    localparam int BIT_DFAULT  = 1;
    localparam int BIT_SFAULT  = 0;
    // Config fields
    localparam int BIT_DONE_IE = 7;
    localparam int BIT_IGNORE_SINGLE_FAULT   = 4;
    localparam int BIT_DF_IE   = 1;
    localparam int BIT_SF_IE   = 0;
    // Reset values
    localparam logic [7:0] RST_CONFIG     = 8'h00;
    localparam logic [7:0] RST_ERR_CONFIG = 8'h00;
    localparam logic       RST_DONE       = 1'b1;
endpackage

// ### verilog/fsef_top.sv
/*
 * Flash status and error flag register bank with Wishbone slave.
 * Assumes the command engine and array read path drive one-cycle event
 * pulses synchronous to sys_clk_in; it launches commands on cmd_launch_out.
 */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module fsef_top #(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    // Wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [ADDR_W-1:0] wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    // Command engine
    input  wire logic              cmd_done_in,
    input  wire logic              seq_violation_in,
    input  wire logic              prot_violation_in,
    input  wire logic              seq_start_in,
    input  wire logic              completion_err_set_in,
    input  wire logic [1:0]        completion_err_in,
    // Reset sequence status
    input  wire logic              reset_seq_dfault_in,
    input  wire logic [1:0]        reset_seq_err_in,
    // Array read path
    input  wire logic              read_single_fault_in,
    input  wire logic              read_double_fault_in,
    input  wire logic              read_collision_in,
    // Outputs to the controller
    output logic                   cmd_launch_out,
    output logic                   seq_start_ok_out,
    output logic                   controller_busy_out,
    output logic                   irq_out
);

    // Elaboration check: the register index needs address bits 5:2
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("ADDR_W must be at least 6");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic       bus_req;
    logic       wr_stb;
    logic [3:0] reg_idx;
    logic       lane0;
    logic [7:0] wdata;

    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign reg_idx = wb_adr_in[5:2];
    assign lane0   = wb_sel_in[0];
    assign wdata   = wb_dat_in[7:0];
    assign wr_stb  = bus_req && wb_we_in && lane0;

    logic wr_cmd;
    logic wr_err;
    logic wr_cfg;
    logic wr_ecfg;

    assign wr_cmd  = wr_stb && (reg_idx == fsef_pkg::IDX_CMD_STATUS);
    assign wr_err  = wr_stb && (reg_idx == fsef_pkg::IDX_ERR_STATUS);
    assign wr_cfg  = wr_stb && (reg_idx == fsef_pkg::IDX_CONFIG);
    assign wr_ecfg = wr_stb && (reg_idx == fsef_pkg::IDX_ERR_CONFIG);

    ////////////////////////////////////////////////////////////////////////
    // Flag state
    logic       done_flag;
    logic       access_error_flag_flag;
    logic       prot_flag;
    logic [1:0] cstat;
    logic       dfault_flag;
    logic       sfault_flag;
    logic [7:0] cfg;
    logic [7:0] ecfg;
    logic       reset_seen;

    // Launch allowed only with both error flags clear before this write
    logic launch;
    assign launch = wr_cmd && wdata[fsef_pkg::BIT_DONE] && done_flag
                    && !access_error_flag_flag && !prot_flag;

    // Configuration registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg  <= fsef_pkg::RST_CONFIG;
            ecfg <= fsef_pkg::RST_ERR_CONFIG;
        end else begin
            if (wr_cfg) begin
                cfg <= wdata & 8'h93;
            end
            if (wr_ecfg) begin
                ecfg <= wdata & 8'h03;
            end
        end
    end

    // Command done flag: cleared by launch, set on completion or violation
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_flag <= fsef_pkg::RST_DONE;
        end else if (cmd_done_in || seq_violation_in || prot_violation_in) begin
            done_flag <= 1'b1;
        end else if (launch) begin
            done_flag <= 1'b0;
        end
    end

    // Access error flag, write one to clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            access_error_flag_flag <= 1'b0;
        end else if (seq_violation_in) begin
            access_error_flag_flag <= 1'b1;
        end else if (wr_cmd && wdata[fsef_pkg::BIT_ACCESS_ERROR_FLAG]) begin
            access_error_flag_flag <= 1'b0;
        end
    end

    // Protection violation flag, write one to clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prot_flag <= 1'b0;
        end else if (prot_violation_in) begin
            prot_flag <= 1'b1;
        end else if (wr_cmd && wdata[fsef_pkg::BIT_PROT]) begin
            prot_flag <= 1'b0;
        end
    end

    // Completion status: hardware only, reset sequence loads it once
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cstat      <= 2'b00;
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= 1'b1;
            if (!reset_seen) begin
                cstat <= reset_seq_err_in;
            end else if (launch || completion_err_set_in) begin
                // Error set wins over the clear made by a launch
                cstat <= (launch ? 2'b00 : cstat)
                         | (completion_err_set_in ? completion_err_in : 2'b00);
            end
        end
    end

    // Fault sources: with ignore clear, collision sets both, genuine faults exactly one
    logic set_df;
    logic set_sf;
    logic real_sf;

    assign real_sf = read_single_fault_in && !read_double_fault_in;
    assign set_df  = read_double_fault_in || read_collision_in
                     || (!reset_seen && reset_seq_dfault_in);
    assign set_sf  = (real_sf || read_collision_in)
                     && !cfg[fsef_pkg::BIT_IGNORE_SINGLE_FAULT];

    // Double fault flag, write one to clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dfault_flag <= 1'b0;
        end else if (set_df) begin
            dfault_flag <= 1'b1;
        end else if (wr_err && wdata[fsef_pkg::BIT_DFAULT]) begin
            dfault_flag <= 1'b0;
        end
    end

    // Single fault flag, write one to clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sfault_flag <= 1'b0;
        end else if (set_sf) begin
            sfault_flag <= 1'b1;
        end else if (wr_err && wdata[fsef_pkg::BIT_SFAULT]) begin
            sfault_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data assembly
    logic [7:0] cmd_status;
    logic [7:0] err_status;
    logic [7:0] rd_byte;

    always_comb begin
        cmd_status = 8'h00;
        cmd_status[fsef_pkg::BIT_DONE]   = done_flag;
        cmd_status[fsef_pkg::BIT_ACCESS_ERROR_FLAG] = access_error_flag_flag;
        cmd_status[fsef_pkg::BIT_PROT]   = prot_flag;
        cmd_status[fsef_pkg::BIT_BUSY]   = !done_flag;
        cmd_status[fsef_pkg::BIT_CSTAT_H:fsef_pkg::BIT_CSTAT_L] = cstat;
        err_status = 8'h00;
        err_status[fsef_pkg::BIT_DFAULT] = dfault_flag;
        err_status[fsef_pkg::BIT_SFAULT] = sfault_flag;
    end

    always_comb begin
        case (reg_idx)
            fsef_pkg::IDX_CONFIG:     rd_byte = cfg;
            fsef_pkg::IDX_ERR_CONFIG: rd_byte = ecfg;
            fsef_pkg::IDX_CMD_STATUS: rd_byte = cmd_status;
            fsef_pkg::IDX_ERR_STATUS: rd_byte = err_status;
            default:                  rd_byte = 8'h00;
        endcase
    end

    // Bus answer one cycle after request
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req && !wb_we_in) begin
                wb_dat_out <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller outputs and interrupt request
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_launch_out      <= 1'b0;
            seq_start_ok_out    <= 1'b0;
            controller_busy_out <= 1'b0;
            irq_out             <= 1'b0;
        end else begin
            cmd_launch_out      <= launch;
            seq_start_ok_out    <= !prot_flag && !prot_violation_in;
            controller_busy_out <= !done_flag;
            irq_out <= (cfg[fsef_pkg::BIT_DONE_IE] && done_flag)
                    || (ecfg[fsef_pkg::BIT_DF_IE] && dfault_flag)
                    || (ecfg[fsef_pkg::BIT_SF_IE] && sfault_flag);
        end
    end

endmodule

// ### bench/fsef_checker.sv
/* Checker for the flash status flag bank: bus answer timing and launch control.
   Assumes one clock domain and that it is bound to every instance of fsef_top. */
`timescale 1ns/1ps
module fsef_checker #(
    parameter int ADDR_W = 6
) (
    // Clock, reset and bus
    input wire logic              sys_clk_in,
    input wire logic              rst_in,
    input wire logic              wb_cyc_in,
    input wire logic              wb_stb_in,
    input wire logic              wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0]        wb_sel_in,
    input wire logic [31:0]       wb_dat_in,
    input wire logic [31:0]       wb_dat_out,
    input wire logic              wb_ack_out,
    // Controller side
    input wire logic              cmd_done_in,
    input wire logic              prot_violation_in,
    input wire logic              cmd_launch_out,
    input wire logic              seq_start_ok_out,
    input wire logic              controller_busy_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer comes one cycle after a taken request and lasts one cycle
    property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    // Unused read bits are zero
    property p_read_upper; wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0; endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper bits set");
    property p_reserved_bit;
        wb_ack_out && !wb_we_in && wb_adr_in[5:2] == 4'h6 |-> !wb_dat_out[2];
    endproperty
    a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit set");
    // Launch only from a write of one to the done bit while not blocked
    property p_launch_cause;
        cmd_launch_out |-> $past(wb_we_in && wb_adr_in[5:2] == 4'h6 && wb_dat_in[7]
                                 && wb_sel_in[0] && seq_start_ok_out);
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("bad launch");
    property p_launch_pulse; cmd_launch_out |=> !cmd_launch_out; endproperty
    a_launch_pulse: assert property (p_launch_pulse) else $error("launch too long");
    // Busy follows a launch and falls after completion
    property p_busy_launch; cmd_launch_out |-> ##[0:1] controller_busy_out; endproperty
    a_busy_launch: assert property (p_busy_launch) else $error("busy missing");
    property p_busy_done; cmd_done_in |-> ##[1:2] !controller_busy_out; endproperty
    a_busy_done: assert property (p_busy_done) else $error("busy stuck");
    // Protection flag blocks the start of a sequence
    property p_prot_block; prot_violation_in |-> ##[1:2] !seq_start_ok_out; endproperty
    a_prot_block: assert property (p_prot_block) else $error("start allowed");
    c_launch: cover property (cmd_launch_out);
    c_prot: cover property (prot_violation_in);
    c_read: cover property (wb_ack_out && !wb_we_in);
endmodule
bind fsef_top fsef_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_in, .rst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .cmd_done_in, .prot_violation_in, .cmd_launch_out, .seq_start_ok_out,
    .controller_busy_out);

// ### bench/fsef_top_bench.sv
/* Self-checking bench for the flash status flag bank.
   Assumes fsef_top with a Wishbone slave and one-cycle event pulse inputs. */
`timescale 1ns/1ps
module fsef_top_bench;
    logic        sys_clk_in, rst_in, cyc, stb, we, ack, launch, ok, busy, irq;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [6:0]  ev;
    logic [1:0]  cerr;
    int          n_fail, tests_run, n_launch, cycles;
    fsef_top u_dut (.sys_clk_in, .rst_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .cmd_done_in(ev[0]), .seq_violation_in(ev[1]), .prot_violation_in(ev[2]),
        .seq_start_in(1'b0), .completion_err_set_in(ev[3]), .completion_err_in(cerr),
        .reset_seq_dfault_in(1'b0), .reset_seq_err_in(2'h0), .read_single_fault_in(ev[4]),
        .read_double_fault_in(ev[5]), .read_collision_in(ev[6]), .cmd_launch_out(launch),
        .seq_start_ok_out(ok), .controller_busy_out(busy), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, launch counter and hang limit
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        n_launch += int'(launch === 1'b1);
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // One classic bus cycle; request held until the edge that samples ack high
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge sys_clk_in);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, idx, 2'b00, 24'h0, d};
        do @(posedge sys_clk_in); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk({24'h0, exp}, q);
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge sys_clk_in);
        ev <= m;
        @(posedge sys_clk_in);
        ev <= 7'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {cyc, stb, we, adr, wdat, ev} = '0;
        sel = 4'hf;
        cerr = 2'h1;
        rst_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(4'h6, 8'h80);
        rd(4'h7, 8'h00);
        rd(4'h1, 8'h00);
        bus(1'b1, 4'h6, 8'h80);
        rd(4'h6, 8'h08);
        pulse(7'h08);
        pulse(7'h01);
        rd(4'h6, 8'h81);
        bus(1'b1, 4'h6, 8'h0f);
        rd(4'h6, 8'h81);
        pulse(7'h02);
        bus(1'b1, 4'h6, 8'h80);
        rd(4'h6, 8'ha1);
        bus(1'b1, 4'h6, 8'h00);
        rd(4'h6, 8'ha1);
        bus(1'b1, 4'h6, 8'h20);
        rd(4'h6, 8'h81);
        pulse(7'h04);
        rd(4'h6, 8'h91);
        chk(32'h0, {31'h0, ok});
        bus(1'b1, 4'h6, 8'h00);
        rd(4'h6, 8'h91);
        bus(1'b1, 4'h6, 8'h90);
        rd(4'h6, 8'h81);
        bus(1'b1, 4'h6, 8'h80);
        rd(4'h6, 8'h08);
        chk(32'h1, {31'h0, busy});
        pulse(7'h01);
        chk(32'h2, n_launch);
        pulse(7'h10);
        bus(1'b1, 4'h7, 8'h00);
        rd(4'h7, 8'h01);
        bus(1'b1, 4'h7, 8'h01);
        pulse(7'h30);
        rd(4'h7, 8'h02);
        bus(1'b1, 4'h5, 8'h02);
        rd(4'h5, 8'h02);
        chk(32'h1, {31'h0, irq});
        bus(1'b1, 4'h7, 8'h02);
        rd(4'h7, 8'h00);
        chk(32'h0, {31'h0, irq});
        pulse(7'h40);
        rd(4'h7, 8'h03);
        bus(1'b1, 4'h7, 8'h03);
        bus(1'b1, 4'h4, 8'h90);
        rd(4'h4, 8'h90);
        chk(32'h1, {31'h0, irq});
        pulse(7'h10);
        rd(4'h7, 8'h00);
        tally_and_finish();
    end
endmodule
